// ===== design/lam_pkg.sv
/*
  Constants and helpers shared by the limit alarm monitor and its
  threshold store. Assumes a 32-bit Avalon-MM register bus with byte
  addresses and 12-bit conversion results.
*/
package lam_pkg;

  localparam int DATA_W = 12;
  localparam int EXT_W = 14;
  localparam int HYS_W = 7;
  localparam int NCH = 7;
  localparam int NFLAG = 11;
  localparam int CNT_W = 9;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] STAT_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] EN_OFS = 8'h08;
  localparam logic [7:0] GLOB_OFS = 8'h0C;
  localparam logic [7:0] THR_BASE = 8'h40;
  localparam logic [7:0] THR_END = 8'hB0;

  // threshold word index inside one channel block of 16 bytes
  localparam logic [1:0] FLD_HI = 2'h0;
  localparam logic [1:0] FLD_LO = 2'h1;
  localparam logic [1:0] FLD_HYS = 2'h2;

  // control register field positions
  localparam int CTRL_CH_LSB = 0;
  localparam int CTRL_TP_LSB = 4;
  localparam int CTRL_LATCH_BIT = 8;
  localparam int CTRL_SWRST_BIT = 9;

  // channel numbering: 0..3 analog, 4 remote one, 5 remote two, 6 local
  localparam logic [2:0] FIRST_TEMP_CH = 3'h4;
  localparam int OVERTEMP_BIT = 10;

  // values after reset
  localparam logic [2:0] CH_SEL_RST = 3'h3;
  localparam logic [1:0] TP_SEL_RST = 2'h2;
  localparam logic [NFLAG-1:0] EN_RST = 11'h7FF;
  localparam logic [DATA_W-1:0] AN_HI_RST = 12'hFFF;
  localparam logic [DATA_W-1:0] AN_LO_RST = 12'h000;
  localparam logic [DATA_W-1:0] TP_HI_RST = 12'h7FF;
  localparam logic [DATA_W-1:0] TP_LO_RST = 12'h800;
  localparam logic [HYS_W-1:0] HYS_RST = 7'h00;

  // die over-temperature trip and its fixed hysteresis, whole degrees
  localparam logic [EXT_W-1:0] OVERTEMP_C = 14'h0096;
  localparam logic [EXT_W-1:0] OVERTEMP_HYS_C = 14'h0008;

  // widen a result: temperatures are signed, analog codes unsigned
  function automatic logic signed [EXT_W-1:0] ext(
    input logic [DATA_W-1:0] v,
    input logic is_temp
  );
    logic sgn;
    sgn = is_temp & v[DATA_W-1];
    ext = {{(EXT_W-DATA_W){sgn}}, v};
  endfunction

  // consecutive out-of-range count needed before a flag sets
  function automatic logic [CNT_W-1:0] need_n(
    input logic [2:0] sel,
    input logic is_temp
  );
    if (is_temp) begin
      need_n = CNT_W'(1) << sel[1:0];
    end else if (sel == 3'h0) begin
      need_n = CNT_W'(1);
    end else begin
      // widened so that select 7 shifts by 8 instead of wrapping to 0
      need_n = CNT_W'(1) << ({1'b0, sel} + 4'h1);
    end
  endfunction

endpackage

// ===== design/lam_thr_if.sv
/*
  Carrier between the alarm core and its threshold store.
  Assumes one write port and one registered read port.
*/
`timescale 1ns/10ps
interface lam_thr_if;
  logic clear;
  logic wr_en;
  logic [2:0] wr_ch;
  logic [1:0] wr_fld;
  logic [lam_pkg::DATA_W-1:0] wr_data;
  logic rd_en;
  logic [2:0] rd_ch;
  logic [lam_pkg::DATA_W-1:0] rd_hi;
  logic [lam_pkg::DATA_W-1:0] rd_lo;
  logic [lam_pkg::HYS_W-1:0] rd_hys;

  modport core (
    output clear, wr_en, wr_ch, wr_fld, wr_data, rd_en, rd_ch,
    input rd_hi, rd_lo, rd_hys
  );
  modport mem (
    input clear, wr_en, wr_ch, wr_fld, wr_data, rd_en, rd_ch,
    output rd_hi, rd_lo, rd_hys
  );
endinterface

// ===== design/lam_thr_mem.sv
/*
  Threshold store: upper bound, lower bound and hysteresis per channel.
  Assumes the core never reads and writes the same word expecting the
  new value in the same cycle; read data come from a register.
*/
`timescale 1ns/10ps
module lam_thr_mem (
  input wire logic clk,
  input wire logic rst,
  lam_thr_if.mem port
);

  typedef struct packed {
    logic [lam_pkg::DATA_W-1:0] hi;
    logic [lam_pkg::DATA_W-1:0] lo;
    logic [lam_pkg::HYS_W-1:0] hys;
  } lam_ent_t;

  typedef struct packed {
    lam_ent_t [lam_pkg::NCH-1:0] ent;
    lam_ent_t rd;
  } lam_mem_t;

  // single-bound detection works by leaving the other bound at reset
  function automatic lam_mem_t mem_rst();
    lam_mem_t m;
    m = '0;
    for (int i = 0; i < lam_pkg::NCH; i++) begin
      m.ent[i].hi = (i >= lam_pkg::FIRST_TEMP_CH) ?
                    lam_pkg::TP_HI_RST : lam_pkg::AN_HI_RST;
      m.ent[i].lo = (i >= lam_pkg::FIRST_TEMP_CH) ?
                    lam_pkg::TP_LO_RST : lam_pkg::AN_LO_RST;
      m.ent[i].hys = lam_pkg::HYS_RST;
    end
    mem_rst = m;
  endfunction

  localparam lam_mem_t MEM_RST = mem_rst();

  lam_mem_t s_q;
  lam_mem_t s_d;

  ////////////////////////////////////////////////////////////////////
  // write one field, read a whole entry
  always_comb begin
    s_d = s_q;
    if (port.rd_en) begin
      s_d.rd = s_q.ent[port.rd_ch];
    end
    if (port.wr_en) begin
      unique case (port.wr_fld)
        lam_pkg::FLD_HI: s_d.ent[port.wr_ch].hi = port.wr_data;
        lam_pkg::FLD_LO: s_d.ent[port.wr_ch].lo = port.wr_data;
        lam_pkg::FLD_HYS: begin
          s_d.ent[port.wr_ch].hys = port.wr_data[lam_pkg::HYS_W-1:0];
        end
        default: ;
      endcase
    end
    if (port.clear) begin
      s_d = MEM_RST;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= MEM_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.rd_hi = s_q.rd.hi;
  assign port.rd_lo = s_q.rd.lo;
  assign port.rd_hys = s_q.rd.hys;

endmodule

// ===== design/lam_core.sv
/*
  Limit alarm monitor: window checks with hysteresis and a consecutive
  sample filter on four analog and three temperature channels, plus a
  die over-temperature flag, status flags and an open-drain alarm pin.
  Assumes conversion results arrive as one-cycle strobes synchronous
  to clk, and registers are reached over Avalon-MM with waitrequest.
*/
// The Avalon-MM slave port and the address map were decided locally.
// Operation
// - four analog channels each own a flag
// - upper and lower bound form each window
// - temperature channels keep upper and lower flags
// - upper below lower forces flag permanently set
// - alarm pin is open drain, low active
// - per-source enable gates pin, not flag
// - latched flag needs cleared condition and read
// - latched flag cleared by read or reset
// - status read clears flags, persisting ones return
// - unlatched flag follows condition
// - clearing needs result past hysteresis margin
// - programmable hysteresis per channel
// - die over-temperature hysteresis fixed at eight
// - flag sets after N consecutive outside results
// - analog count select: 1,4,8,16..256
// - temperature count select: 1,2,4,8
// - global flag is OR of all flags
// - die above 150 degrees sets over-temperature flag
`timescale 1ns/10ps
module lam_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic [lam_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic conv_valid,
  input wire logic [2:0] conv_chan,
  input wire logic [lam_pkg::DATA_W-1:0] conv_data,
  input wire logic die_temp_valid,
  input wire logic [lam_pkg::DATA_W-1:0] die_temp,
  input wire logic alarm_n_i,
  output logic alarm_n_o,
  output logic alarm_n_oe
);

  typedef enum logic [1:0] {ST_IDLE, ST_MRD, ST_ANS} lam_bus_t;

  typedef struct packed {
    lam_bus_t st;
    logic wait_r;
    logic [31:0] rdata;
    logic [1:0] fld;
    logic [lam_pkg::NFLAG-1:0] flag;
    logic [lam_pkg::NFLAG-1:0] act;
    logic [3:0] inv;
    logic [lam_pkg::NCH-1:0][lam_pkg::CNT_W-1:0] cnt;
    logic [2:0] ch_sel;
    logic [1:0] tp_sel;
    logic latch_dis;
    logic [lam_pkg::NFLAG-1:0] en;
    logic cv;
    logic [2:0] cv_ch;
    logic [lam_pkg::DATA_W-1:0] cv_data;
    logic pin_oe;
  } lam_state_t;

  localparam lam_state_t ST_RST = '{
    st: ST_IDLE,
    wait_r: 1'b1,
    ch_sel: lam_pkg::CH_SEL_RST,
    tp_sel: lam_pkg::TP_SEL_RST,
    en: lam_pkg::EN_RST,
    default: '0
  };

  lam_state_t s_q;
  lam_state_t s_d;
  lam_thr_if thr ();

  lam_thr_mem u_mem (
    .clk(clk),
    .rst(rst),
    .port(thr.mem)
  );

  // merge a bus write into a register under the byte enables
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = be[b] ? wd[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // comparison terms for the conversion held in stage two
  logic is_temp;
  logic signed [lam_pkg::EXT_W-1:0] v_x, hi_x, lo_x, hys_x;
  logic over, under, out_rng, clr_hi, clr_lo;
  logic [lam_pkg::CNT_W-1:0] cnt_nx;
  logic reach;
  logic [3:0] f_up, f_lo;

  always_comb begin
    is_temp = s_q.cv_ch >= lam_pkg::FIRST_TEMP_CH;
    v_x = lam_pkg::ext(s_q.cv_data, is_temp);
    hi_x = lam_pkg::ext(thr.rd_hi, is_temp);
    lo_x = lam_pkg::ext(thr.rd_lo, is_temp);
    hys_x = {{(lam_pkg::EXT_W-lam_pkg::HYS_W){1'b0}}, thr.rd_hys};
    over = v_x > hi_x;
    under = v_x < lo_x;
    out_rng = over | under;
    // margin back inside the window before a set flag may drop
    clr_hi = v_x <= (hi_x - hys_x);
    clr_lo = v_x >= (lo_x + hys_x);
    // counter saturates well above the largest N, so no wrap
    if (!out_rng) begin
      cnt_nx = '0;
    end else if (&s_q.cnt[s_q.cv_ch]) begin
      cnt_nx = s_q.cnt[s_q.cv_ch];
    end else begin
      cnt_nx = s_q.cnt[s_q.cv_ch] + lam_pkg::CNT_W'(1);
    end
    reach = out_rng &&
            cnt_nx >= lam_pkg::need_n(is_temp ? {1'b0, s_q.tp_sel} :
                                      s_q.ch_sel, is_temp);
    // temperature channel c keeps flags 2c-4 (upper) and 2c-3 (lower)
    f_up = {s_q.cv_ch, 1'b0} - 4'h4;
    f_lo = {s_q.cv_ch, 1'b0} - 4'h3;
  end

  ////////////////////////////////////////////////////////////////////
  // next state: bus slave, threshold port, flag evaluation
  logic bus_req, thr_hit, stat_rd;
  logic [2:0] a_ch;
  logic [lam_pkg::ADDR_W-1:0] a_off;
  logic [lam_pkg::NFLAG-1:0] clr_mask;
  logic act_n, act_u, act_l;
  logic signed [lam_pkg::EXT_W-1:0] dt_x;

  always_comb begin
    s_d = s_q;
    bus_req = avs_read | avs_write;
    thr_hit = avs_address >= lam_pkg::THR_BASE &&
              avs_address < lam_pkg::THR_END;
    a_off = avs_address - lam_pkg::THR_BASE;
    a_ch = a_off[6:4];
    stat_rd = 1'b0;
    clr_mask = '0;
    act_n = 1'b0;
    act_u = 1'b0;
    act_l = 1'b0;
    dt_x = lam_pkg::ext(die_temp, 1'b1);
    thr.clear = 1'b0;
    thr.wr_en = 1'b0;
    thr.wr_ch = a_ch;
    thr.wr_fld = a_off[3:2];
    thr.wr_data = avs_writedata[lam_pkg::DATA_W-1:0];
    // conversions own the read port; bus reads wait for a free cycle
    thr.rd_en = conv_valid;
    thr.rd_ch = conv_valid ? conv_chan : a_ch;
    s_d.cv = conv_valid;
    if (conv_valid) begin
      s_d.cv_ch = conv_chan;
      s_d.cv_data = conv_data;
    end

    // bus slave: answer is one cycle of waitrequest low
    unique case (s_q.st)
      ST_IDLE: begin
        if (bus_req) begin
          s_d.rdata = '0;
          s_d.fld = a_off[3:2];
          s_d.st = ST_ANS;
          s_d.wait_r = 1'b0;
          if (thr_hit && avs_read) begin
            if (conv_valid) begin
              s_d.st = ST_IDLE;
              s_d.wait_r = 1'b1;
            end else begin
              thr.rd_en = 1'b1;
              s_d.st = ST_MRD;
              s_d.wait_r = 1'b1;
            end
          end else if (thr_hit) begin
            // writes to a threshold word without both low byte enables are ignored
            thr.wr_en = &avs_byteenable[1:0];
          end else if (avs_read) begin
            unique case (avs_address)
              lam_pkg::STAT_OFS: begin
                s_d.rdata[lam_pkg::NFLAG-1:0] = s_q.flag;
                stat_rd = 1'b1;
              end
              lam_pkg::CTRL_OFS: begin
                s_d.rdata[lam_pkg::CTRL_CH_LSB +: 3] = s_q.ch_sel;
                s_d.rdata[lam_pkg::CTRL_TP_LSB +: 2] = s_q.tp_sel;
                s_d.rdata[lam_pkg::CTRL_LATCH_BIT] = s_q.latch_dis;
              end
              lam_pkg::EN_OFS: s_d.rdata[lam_pkg::NFLAG-1:0] = s_q.en;
              lam_pkg::GLOB_OFS: begin
                s_d.rdata[0] = |s_q.flag;
                s_d.rdata[1] = alarm_n_i;
              end
              default: ;
            endcase
          end else begin
            unique case (avs_address)
              lam_pkg::CTRL_OFS: begin
                // latch bit sits at 8; the reset bit 9 never merges back
                s_d.rdata = merge({23'h0, s_q.latch_dis, 2'h0,
                                   s_q.tp_sel, 1'b0, s_q.ch_sel},
                                  avs_writedata, avs_byteenable);
                s_d.ch_sel = s_d.rdata[lam_pkg::CTRL_CH_LSB +: 3];
                s_d.tp_sel = s_d.rdata[lam_pkg::CTRL_TP_LSB +: 2];
                s_d.latch_dis = s_d.rdata[lam_pkg::CTRL_LATCH_BIT];
                thr.clear = s_d.rdata[lam_pkg::CTRL_SWRST_BIT];
                s_d.rdata = '0;
              end
              lam_pkg::EN_OFS: begin
                s_d.rdata = merge({21'h0, s_q.en}, avs_writedata,
                                  avs_byteenable);
                s_d.en = s_d.rdata[lam_pkg::NFLAG-1:0];
                s_d.rdata = '0;
              end
              default: ;
            endcase
          end
        end
      end
      ST_MRD: begin
        unique case (s_q.fld)
          lam_pkg::FLD_HI: s_d.rdata = {20'h0, thr.rd_hi};
          lam_pkg::FLD_LO: s_d.rdata = {20'h0, thr.rd_lo};
          lam_pkg::FLD_HYS: s_d.rdata = {25'h0, thr.rd_hys};
          default: s_d.rdata = '0;
        endcase
        s_d.wait_r = 1'b0;
        s_d.st = ST_ANS;
      end
      ST_ANS: begin
        s_d.wait_r = 1'b1;
        s_d.st = ST_IDLE;
      end
    endcase

    // a status read clears every flag; sets below still win
    if (stat_rd) begin
      clr_mask = '1;
    end
    s_d.flag = s_q.flag & ~clr_mask;

    // flag evaluation for the conversion whose thresholds just came
    if (s_q.cv) begin
      s_d.cnt[s_q.cv_ch] = cnt_nx;
      if (!is_temp) begin
        // an inverted window keeps the flag up on every pass
        s_d.inv[s_q.cv_ch[1:0]] = hi_x < lo_x;
        act_n = s_q.act[s_q.cv_ch] ? !(clr_hi && clr_lo) : reach;
        s_d.act[s_q.cv_ch] = act_n;
        if (s_q.latch_dis) begin
          s_d.flag[s_q.cv_ch] = act_n;
        end else begin
          s_d.flag[s_q.cv_ch] = s_d.flag[s_q.cv_ch] | act_n;
        end
      end else begin
        act_u = s_q.act[f_up] ? !clr_hi : reach && over;
        act_l = s_q.act[f_lo] ? !clr_lo : reach && under;
        s_d.act[f_up] = act_u;
        s_d.act[f_lo] = act_l;
        if (s_q.latch_dis) begin
          s_d.flag[f_up] = act_u;
          s_d.flag[f_lo] = act_l;
        end else begin
          s_d.flag[f_up] = s_d.flag[f_up] | act_u;
          s_d.flag[f_lo] = s_d.flag[f_lo] | act_l;
        end
      end
    end

    // die temperature: no count filter, fixed margin to drop
    if (die_temp_valid) begin
      act_n = s_q.act[lam_pkg::OVERTEMP_BIT] ?
              dt_x > $signed(lam_pkg::OVERTEMP_C -
                             lam_pkg::OVERTEMP_HYS_C) :
              dt_x > $signed(lam_pkg::OVERTEMP_C);
      s_d.act[lam_pkg::OVERTEMP_BIT] = act_n;
      if (s_q.latch_dis) begin
        s_d.flag[lam_pkg::OVERTEMP_BIT] = act_n;
      end else begin
        s_d.flag[lam_pkg::OVERTEMP_BIT] =
          s_d.flag[lam_pkg::OVERTEMP_BIT] | act_n;
      end
    end

    s_d.flag[3:0] = s_d.flag[3:0] | s_d.inv;

    // software reset returns everything to defaults but ends the access
    if (thr.clear) begin
      s_d = ST_RST;
      s_d.st = ST_ANS;
      s_d.wait_r = 1'b0;
    end

    // masked sources still flag but never pull the pin
    s_d.pin_oe = |(s_d.flag & s_d.en);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs from the state register, except alarm_n_o which is tied low
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wait_r;
  assign alarm_n_o = 1'b0; // open drain only ever drives low
  assign alarm_n_oe = s_q.pin_oe;

endmodule

// ===== dv/lam_core_props.sv
/*
  Checker for the limit alarm monitor, bound to lam_core.
  Assumes one clock, async active-high reset, and a master that raises
  a request only after the previous answer edge.
*/
`timescale 1ns/10ps
module lam_core_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [lam_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic conv_valid,
  input wire logic [2:0] conv_chan,
  input wire logic [lam_pkg::DATA_W-1:0] conv_data,
  input wire logic die_temp_valid,
  input wire logic [lam_pkg::DATA_W-1:0] die_temp,
  input wire logic alarm_n_i,
  input wire logic alarm_n_o,
  input wire logic alarm_n_oe
);
  logic [2:0] since_q;
  logic [2:0] since_d;
  //////////////////////////////////////////////////////////////////////
  // cycles since a possible cause; saturates so it never wraps to 0
  always_comb begin
    since_d = (since_q == 3'h7) ? since_q : since_q + 3'h1;
    if (avs_read || avs_write || conv_valid || die_temp_valid) begin
      since_d = 3'h0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_q <= 3'h7;
    end else begin
      since_q <= since_d;
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take;
    $rose(avs_read) || $rose(avs_write);
  endsequence
  sequence s_fast_take;
    $rose(avs_write) || ($rose(avs_read) && avs_address <= 8'h0C);
  endsequence
  sequence s_answer;
    !avs_waitrequest;
  endsequence
  // the pin is only ever pulled low, released otherwise
  a_drive_low_only: assert property (alarm_n_o == 1'b0)
    else $error("alarm pin driven high");
  // the pin moves only shortly after a conversion or an access
  a_pin_has_cause: assert property (
    $changed(alarm_n_oe) |-> since_q <= 3'h3)
    else $error("alarm pin changed without cause");
  a_fast_answer: assert property (s_fast_take |=> s_answer)
    else $error("register access not answered next cycle");
  a_slow_answer: assert property (s_take |-> ##[1:40] s_answer)
    else $error("access never answered");
  a_one_cycle: assert property (s_answer |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  a_idle_wait: assert property (!avs_read && !avs_write |-> avs_waitrequest)
    else $error("answer with no request");
  a_stat_width: assert property (
    !avs_waitrequest && avs_read && avs_address == 8'h00
    |-> avs_readdata[31:11] == 21'h0)
    else $error("status has bits above the flags");
  a_unmapped_zero: assert property (
    !avs_waitrequest && avs_read && avs_address inside {[8'h10:8'h3C]}
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_in_reset: assert property (disable iff (1'b0)
    rst |-> !alarm_n_oe && avs_waitrequest)
    else $error("outputs active during reset");
endmodule

// ===== dv/lam_host_model.sv
/*
  Host side of the alarm pin: open-drain wire with pull-up and an
  interrupt latch. Assumes the bench services the interrupt and acks.
*/
`timescale 1ns/10ps
module lam_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic alarm_n_o,
  input wire logic alarm_n_oe,
  input wire logic ack,
  output logic alarm_wire,
  output logic irq_q
);
  // released wire goes to the pull-up level, never holds a stale value
  assign alarm_wire = alarm_n_oe ? alarm_n_o : 1'b1;
  // low wire is an interrupt request, held until the host has serviced it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (!alarm_wire) begin
      irq_q <= 1'b1;
    end else if (ack) begin
      irq_q <= 1'b0;
    end
  end
endmodule

// ===== dv/limit_alarm_monitor_tb.sv
/*
  Self-checking bench for lam_core: Avalon-MM master tasks, conversion
  strobes and host model. Assumes the answer timing of the hand-over.
*/
`timescale 1ns/10ps
module limit_alarm_monitor_tb;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, conv_valid;
  logic die_temp_valid, alarm_n_o, alarm_n_oe, alarm_wire, irq_q, ack;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [2:0] conv_chan, ch;
  logic [11:0] conv_data, die_temp, v;
  logic [15:0] rnd;
  int errors, comparisons, s, i, b;
  int ntab[8] = '{1, 4, 8, 16, 32, 64, 128, 256};
  logic [11:0] hv[6] = '{12'h900, 12'h782, 12'h781, 12'h0FF, 12'h17E, 12'h17F};
  logic [11:0] dv[4] = '{12'h096, 12'h097, 12'h08F, 12'h08E};
  logic [11:0] cor[4] = '{12'hC00, 12'hC01, 12'h400, 12'h3FF};
  logic hp[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic dp[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  lam_core lam_core_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_data(conv_data),
    .die_temp_valid(die_temp_valid), .die_temp(die_temp),
    .alarm_n_i(alarm_wire), .alarm_n_o(alarm_n_o), .alarm_n_oe(alarm_n_oe));
  lam_host_model lam_host_model_inst (.clk(clk), .rst(rst),
    .alarm_n_o(alarm_n_o), .alarm_n_oe(alarm_n_oe), .ack(ack),
    .alarm_wire(alarm_wire), .irq_q(irq_q));
  //////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic outside(input logic [11:0] x);
    outside = (x > 12'hC00) || (x < 12'h400);
  endfunction
  task wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task pn(input logic e);
    chk("alarm_wire", {31'h0, e}, {31'h0, alarm_wire});
  endtask
  // request held until waitrequest is sampled low; bounded wait
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (k = 0; k < 60; k++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 60) begin
      errors++;
      wrap_up();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("readdata", e, q);
  endtask
  task thr(input logic [2:0] c, input logic [11:0] hi, lo,
    input logic [6:0] hy);
    logic [7:0] base;
    base = lam_pkg::THR_BASE + {1'b0, c, 4'h0};
    bus(1'b1, base, {20'h0, hi});
    bus(1'b1, base + 8'h04, {20'h0, lo});
    bus(1'b1, base + 8'h08, {25'h0, hy});
  endtask
  // strobe, then wait the two edges until flags and pin settle
  task cv(input logic [2:0] c, input logic [11:0] x);
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_chan <= c;
    conv_data <= x;
    @(posedge clk);
    conv_valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task die(input logic [11:0] x);
    @(posedge clk);
    die_temp_valid <= 1'b1;
    die_temp <= x;
    @(posedge clk);
    die_temp_valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst, avs_read, avs_write, conv_valid, die_temp_valid, ack} = 6'h20;
    {avs_address, avs_writedata, conv_chan, conv_data, die_temp} = '0;
    avs_byteenable = 4'hF;
    errors = 0;
    comparisons = 0;
    rnd = 16'h0017;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h23);
    rdc(8'h08, 32'h7FF);
    rdc(8'h20, 32'h0);
    $display("test reset values done");
    // analog filter for every count select, latched flags
    thr(3'h0, 12'h800, 12'h000, 7'h00);
    for (s = 0; s < 8; s++) begin
      bus(1'b1, 8'h04, s);
      repeat (ntab[s] - 1) cv(3'h0, 12'h900);
      cv(3'h0, 12'h100);
      repeat (ntab[s] - 1) cv(3'h0, 12'h900);
      pn(1'b1);
      cv(3'h0, 12'h900);
      pn(1'b0);
      chk("irq", 32'h1, {31'h0, irq_q});
      rdc(8'h00, 32'h1);
      rdc(8'h00, 32'h0);
      cv(3'h0, 12'h900);
      cv(3'h0, 12'h100);
      pn(1'b0);
      rdc(8'h00, 32'h1);
      rdc(8'h00, 32'h0);
      pn(1'b1);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
    end
    $display("test analog filter done");
    // temperature filter, upper and lower flags
    for (i = 4; i < 7; i++) thr(i[2:0], 12'h050, 12'h000, 7'h00);
    for (s = 0; s < 4; s++) begin
      bus(1'b1, 8'h04, s << 4);
      ch = 3'(4 + s % 3);
      v = s[0] ? 12'hFF0 : 12'h064;
      b = 4 + 2 * (ch - 4) + s % 2;
      repeat ((1 << s) - 1) cv(ch, v);
      pn(1'b1);
      cv(ch, v);
      pn(1'b0);
      cv(ch, 12'h020);
      rdc(8'h00, 32'h1 << b);
      rdc(8'h00, 32'h0);
    end
    $display("test temperature filter done");
    // hysteresis at its widest, unlatched
    bus(1'b1, 8'h04, 32'h100);
    thr(3'h1, 12'h800, 12'h100, 7'h7F);
    rdc(8'h58, 32'h7F);
    for (i = 0; i < 6; i++) begin
      cv(3'h1, hv[i]);
      pn(hp[i]);
    end
    rdc(8'h00, 32'h0);
    $display("test hysteresis done");
    // masked source still flags
    bus(1'b1, 8'h08, 32'h7FE);
    cv(3'h0, 12'h900);
    pn(1'b1);
    rdc(8'h00, 32'h1);
    bus(1'b1, 8'h08, 32'h7FF);
    cv(3'h0, 12'h100);
    // die over-temperature with its fixed hysteresis
    for (i = 0; i < 4; i++) begin
      die(dv[i]);
      pn(dp[i]);
    end
    rdc(8'h00, 32'h0);
    $display("test mask and overtemp done");
    // inverted window stays set
    thr(3'h2, 12'h100, 12'h200, 7'h00);
    cv(3'h2, 12'h180);
    rdc(8'h00, 32'h4);
    rdc(8'h60, 32'h100);
    rdc(8'h64, 32'h200);
    rdc(8'h0C, 32'h1);
    repeat (5) @(posedge clk);
    rdc(8'h00, 32'h4);
    $display("test inverted window done");
    // software reset, then random results with corners first
    bus(1'b1, 8'h04, 32'h200);
    rdc(8'h04, 32'h23);
    pn(1'b1);
    bus(1'b1, 8'h04, 32'h100);
    thr(3'h3, 12'hC00, 12'h400, 7'h00);
    for (i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      v = (i < 4) ? cor[i] : rnd[11:0];
      cv(3'h3, v);
      pn(!outside(v));
    end
    $display("test random window done");
    wrap_up();
  end
endmodule
bind lam_core lam_core_props lam_core_props_inst (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_data(conv_data),
  .die_temp_valid(die_temp_valid), .die_temp(die_temp),
  .alarm_n_i(alarm_n_i), .alarm_n_o(alarm_n_o), .alarm_n_oe(alarm_n_oe));
